// ### ids_map.vh
// Purpose: Register map, field positions and reset values of the input deserializer
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Macro definitions only, guarded against double inclusion
`ifndef IDS_MAP_VH
`define IDS_MAP_VH

`define IDS_ADDR_CTRL     4'h0
`define IDS_ADDR_STAT     4'h4

`define IDS_CTRL_WLEN_LSB 0
`define IDS_CTRL_WLEN_MSB 3
`define IDS_CTRL_ROLE_LSB 4
`define IDS_CTRL_ROLE_MSB 5
`define IDS_CTRL_DDR      6
`define IDS_CTRL_SLIPEN   7
`define IDS_CTRL_INV0     8
`define IDS_CTRL_INV1     9
`define IDS_CTRL_RESET    32'h0000_0001

`define IDS_ROLE_NONE     2'h0
`define IDS_ROLE_MASTER   2'h1
`define IDS_ROLE_SLAVE    2'h2

`define IDS_RESP_OKAY     2'h0
`define IDS_RESP_SLVERR   2'h2

`endif

// ### ids_input_deserializer.v
// Purpose: Input deserializer with word slip, cascade and phase detector
// Assumes: All pins sampled by clk; capture and fabric clocks are slow inputs found by edges
// Notes:   Configuration in CTRL, state in STAT over AXI4-Lite
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ids_map.vh"

module ids_input_deserializer (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        serial_in,
    input  wire        capture_clock_primary,
    input  wire        capture_clock_secondary,
    input  wire        capture_strobe,
    input  wire        fabric_clock,
    input  wire        slip_req,
    input  wire        final_reg_enable,
    input  wire        cascade_in,
    output wire        unregistered_sample_out,
    output reg         cascade_out,
    output reg         phase_early_late,
    output reg         phase_valid,
    output reg         parallel_word_out_0,
    output reg         parallel_word_out_1,
    output reg         parallel_word_out_2,
    output reg         parallel_word_out_3
);

    // Effective word length: 0 reads as 1, above four only when cascaded
    function [3:0] eff_len;
        input [3:0] len;
        input [1:0] role;
        begin
            if (len == 4'h0)
                eff_len = 4'h1;
            else if (len > 4'h8)
                eff_len = 4'h8;
            else if (len > 4'h4 && role == `IDS_ROLE_NONE)
                eff_len = 4'h4;
            else
                eff_len = len;
        end
    endfunction

    // Low n bits of a word, n from 0 to 4
    function [3:0] low_bits;
        input [7:0] word;
        input [3:0] n;
        begin
            case (n)
                4'h0:    low_bits = 4'h0;
                4'h1:    low_bits = {3'h0, word[0]};
                4'h2:    low_bits = {2'h0, word[1:0]};
                4'h3:    low_bits = {1'h0, word[2:0]};
                default: low_bits = word[3:0];
            endcase
        end
    endfunction

    reg  [31:0] ctrl_ff;
    reg  [3:0]  awaddr_ff;
    reg         aw_held_ff;
    reg  [31:0] wdata_ff;
    reg  [3:0]  wstrb_ff;
    reg         w_held_ff;
    reg  [7:0]  sync1_ff;
    reg  [7:0]  sync2_ff;
    reg  [7:0]  sync3_ff;
    reg  [7:0]  shift_ff;
    reg  [2:0]  cnt_ff;
    reg  [2:0]  ofs_ff;
    reg  [3:0]  hold_ff;
    reg         prev_ff;
    reg  [2:0]  nxt_cnt;
    reg  [2:0]  nxt_ofs;
    reg  [31:0] nxt_rdata;
    reg  [1:0]  nxt_rresp;
    integer     i;

    wire [3:0] wlen    = eff_len(ctrl_ff[`IDS_CTRL_WLEN_MSB:`IDS_CTRL_WLEN_LSB],
                                 ctrl_ff[`IDS_CTRL_ROLE_MSB:`IDS_CTRL_ROLE_LSB]);
    wire [1:0] role    = ctrl_ff[`IDS_CTRL_ROLE_MSB:`IDS_CTRL_ROLE_LSB];
    wire       ddr     = ctrl_ff[`IDS_CTRL_DDR];
    wire       slip_en = ctrl_ff[`IDS_CTRL_SLIPEN];
    wire       inv0    = ctrl_ff[`IDS_CTRL_INV0];
    wire       inv1    = ctrl_ff[`IDS_CTRL_INV1];
    wire       cascaded = (role != `IDS_ROLE_NONE) && (wlen > 4'h4);
    wire [2:0] last_pos = wlen[2:0] - 3'h1;

    // Synchronised pins: bit 0 data, 1/2 capture clocks, 3 strobe,
    // 4 fabric clock, 5 slip, 6 final enable, 7 cascade in
    wire d_s      = sync2_ff[0];
    wire strobe_s = sync2_ff[3];
    wire slip_s   = sync2_ff[5];
    wire fen_s    = sync2_ff[6];
    wire casc_s   = sync2_ff[7];
    wire rise0    = sync2_ff[1] & ~sync3_ff[1];
    wire fall0    = ~sync2_ff[1] & sync3_ff[1];
    wire rise1    = sync2_ff[2] & ~sync3_ff[2];
    wire fall1    = ~sync2_ff[2] & sync3_ff[2];
    wire fab_edge = sync2_ff[4] & ~sync3_ff[4];

    wire evt0 = inv0 ? fall0 : rise0;
    wire evt1 = ddr & (inv1 ? fall1 : rise1);
    wire evt  = evt0 | evt1;
    // Cascaded slave deserializes the master's fourth stage, others the pin
    wire sample_bit = (role == `IDS_ROLE_SLAVE && cascaded) ? casc_s : d_s;
    wire [7:0] shifted  = {shift_ff[6:0], sample_bit};
    // Word closes on the capture that lands on the last position, one before the strobe when the slip offset is 0
    wire       boundary = evt && (nxt_cnt == last_pos);
    wire       slip_evt = slip_en && slip_s && fab_edge;

    assign unregistered_sample_out = serial_in;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            sync3_ff <= 8'h00;
        end
        else
        begin
            sync1_ff <= {cascade_in, final_reg_enable, slip_req, fabric_clock,
                         capture_strobe, capture_clock_secondary, capture_clock_primary, serial_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Word boundary counter; the strobe re-anchors it at the slip offset
    always @*
    begin
        nxt_ofs = ofs_ff;
        if (!slip_en)
            nxt_ofs = 3'h0;
        else if (slip_evt)
            nxt_ofs = (ofs_ff == last_pos) ? 3'h0 : ofs_ff + 3'h1;
        nxt_cnt = cnt_ff;
        if (evt)
        begin
            if (strobe_s)
                nxt_cnt = ofs_ff;
            else if (cnt_ff >= last_pos)
                nxt_cnt = 3'h0;
            else
                nxt_cnt = cnt_ff + 3'h1;
        end
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_ff            <= 8'h00;
            cnt_ff              <= 3'h0;
            ofs_ff              <= 3'h0;
            hold_ff             <= 4'h0;
            prev_ff             <= 1'b0;
            cascade_out         <= 1'b0;
            phase_early_late    <= 1'b0;
            phase_valid         <= 1'b0;
            parallel_word_out_0 <= 1'b0;
            parallel_word_out_1 <= 1'b0;
            parallel_word_out_2 <= 1'b0;
            parallel_word_out_3 <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            ofs_ff <= nxt_ofs;
            if (evt)
            begin
                shift_ff <= shifted;
                prev_ff  <= d_s;
                if (role == `IDS_ROLE_MASTER)
                    cascade_out <= shifted[3];
                else
                    cascade_out <= sample_bit;
                if (role == `IDS_ROLE_MASTER)
                begin
                    // Transition seen: slave's half-period sample tells early or late
                    phase_valid      <= d_s ^ prev_ff;
                    phase_early_late <= (d_s ^ prev_ff) & (casc_s == d_s);
                end
                else
                begin
                    phase_valid      <= 1'b0;
                    phase_early_late <= 1'b0;
                end
            end
            if (boundary)
            begin
                if (cascaded && role == `IDS_ROLE_MASTER)
                    hold_ff <= shifted[3:0];
                else if (cascaded)
                    hold_ff <= low_bits(shifted, wlen - 4'h4);
                else
                    hold_ff <= low_bits(shifted, wlen);
            end
            if (fab_edge && fen_s)
            begin
                parallel_word_out_0 <= hold_ff[0];
                parallel_word_out_1 <= hold_ff[1];
                parallel_word_out_2 <= hold_ff[2];
                parallel_word_out_3 <= hold_ff[3];
            end
        end
    end

    // AXI4-Lite slave: address and data taken in either order
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire       aw_have = aw_held_ff || s_axi_awvalid;
    wire       w_have  = w_held_ff || s_axi_wvalid;
    wire [3:0] wa      = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wd     = w_held_ff ? wdata_ff : s_axi_wdata;
    wire [3:0] ws      = w_held_ff ? wstrb_ff : s_axi_wstrb;
    wire       wr_go   = aw_have && w_have && !s_axi_bvalid;

    always @*
    begin
        nxt_rresp = `IDS_RESP_OKAY;
        nxt_rdata = 32'h0000_0000;
        case (s_axi_araddr)
            `IDS_ADDR_CTRL: nxt_rdata = {22'h000000, ctrl_ff[9:0]};
            `IDS_ADDR_STAT: nxt_rdata = {14'h0000, phase_valid, phase_early_late,
                                         parallel_word_out_3, parallel_word_out_2,
                                         parallel_word_out_1, parallel_word_out_0,
                                         hold_ff, 1'b0, ofs_ff, 1'b0, cnt_ff};
            default:        nxt_rresp = `IDS_RESP_SLVERR;
        endcase
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ff      <= `IDS_CTRL_RESET;
            awaddr_ff    <= 4'h0;
            aw_held_ff   <= 1'b0;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
            w_held_ff    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `IDS_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `IDS_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready && !wr_go)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_go)
            begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wa == `IDS_ADDR_CTRL)
                begin
                    s_axi_bresp <= `IDS_RESP_OKAY;
                    for (i = 0; i < 2; i = i + 1)
                        if (ws[i])
                            ctrl_ff[i*8 +: 8] <= wd[i*8 +: 8];
                    ctrl_ff[31:10] <= 22'h000000;
                end
                else if (wa == `IDS_ADDR_STAT)
                    s_axi_bresp <= `IDS_RESP_OKAY;
                else
                    s_axi_bresp <= `IDS_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= nxt_rdata;
                s_axi_rresp  <= nxt_rresp;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // ids_input_deserializer

// ### ids_chk_assertions.sv
// Purpose: Port checks of the input deserializer
// Assumes: Pins pass two sync stages and an edge stage
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module ids_chk (
    input wire clk,
    input wire reset_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire serial_in,
    input wire final_reg_enable,
    input wire fabric_clock,
    input wire unregistered_sample_out,
    input wire phase_early_late,
    input wire phase_valid,
    input wire parallel_word_out_0,
    input wire parallel_word_out_1,
    input wire parallel_word_out_2,
    input wire parallel_word_out_3
);
    wire [3:0] word = {parallel_word_out_3, parallel_word_out_2, parallel_word_out_1, parallel_word_out_0};
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    fab_copy_a: assert property (unregistered_sample_out == serial_in) else $error("raw copy differs");
    word_clear_a: assert property ($rose(reset_n) |-> word == 4'h0 && !phase_valid) else $error("not cleared");
    word_hold_a: assert property ((!final_reg_enable) [*5] |-> $stable(word)) else $error("word moved");
    fab_edge_a: assert property ($changed(word) |-> $past(fabric_clock, 2)) else $error("word off fabric edge");
    pd_qual_a: assert property (phase_early_late |-> phase_valid) else $error("phase unqualified");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("no write answer");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not held");
    r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not held");
endmodule // ids_chk

// ### ids_src_model.sv
// Purpose: Serial source behind the tap delay element
// Assumes: Called by the bench just after a clock edge
// Notes:   Link clocks stand still between frames
`timescale 1ns/1ps
module ids_src_model (
    input  wire  clk,
    output logic serial_in,
    output logic capture_clock_primary,
    output logic capture_clock_secondary,
    output logic capture_strobe,
    output logic fabric_clock
);
    initial
    begin
        {serial_in, capture_clock_primary, capture_clock_secondary, capture_strobe, fabric_clock} = 5'h0;
    end
    task fab_pulse;
        fabric_clock <= 1'h1;
        repeat (8) @(posedge clk);
        fabric_clock <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
    // Oldest bit first; the strobe marks every len-th capture
    task send(input logic [7:0] v, input int n, input int len);
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in <= v[i];
            capture_strobe <= (n - 1 - i) % len == 0;
            {capture_clock_primary, capture_clock_secondary} <= 2'h1;
            repeat (8) @(posedge clk);
            {capture_clock_primary, capture_clock_secondary} <= 2'h2;
            repeat (8) @(posedge clk);
        end
        capture_clock_primary <= 1'h0;
        serial_in <= ~v[0];
        fab_pulse;
    endtask
endmodule // ids_src_model

// ### ids_input_deserializer_test.sv
// Purpose: Self-checking bench of the input deserializer
// Assumes: Source model makes the 160 ns link clock
// Notes:   Single unit, word lengths 1 to 4, cascaded master and slave at 6
`timescale 1ns/1ps
module ids_input_deserializer_test;
    logic        clk = 1'h0, reset_n = 1'h0, slip_req = 1'h0, final_reg_enable = 1'h1;
    logic        casc_lvl = 1'h1, mirror = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        serial_in, capture_clock_primary, capture_clock_secondary, capture_strobe, fabric_clock;
    logic        unregistered_sample_out, cascade_out, phase_early_late, phase_valid, parallel_word_out_0;
    logic        parallel_word_out_1, parallel_word_out_2, parallel_word_out_3;
    int          fails = 0, checks = 0;
    wire  [3:0]  word = {parallel_word_out_3, parallel_word_out_2, parallel_word_out_1, parallel_word_out_0};
    // Slave test feeds the inverted pin stream on the cascade input
    wire         cascade_in = mirror ? ~serial_in : casc_lvl;
    ids_input_deserializer DUT (
        .clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .serial_in(serial_in), .capture_clock_primary(capture_clock_primary),
        .capture_clock_secondary(capture_clock_secondary), .capture_strobe(capture_strobe),
        .fabric_clock(fabric_clock), .slip_req(slip_req), .final_reg_enable(final_reg_enable),
        .cascade_in(cascade_in), .unregistered_sample_out(unregistered_sample_out), .cascade_out(cascade_out),
        .phase_early_late(phase_early_late), .phase_valid(phase_valid),
        .parallel_word_out_0(parallel_word_out_0), .parallel_word_out_1(parallel_word_out_1),
        .parallel_word_out_2(parallel_word_out_2), .parallel_word_out_3(parallel_word_out_3)
    );
    ids_src_model src (
        .clk(clk), .serial_in(serial_in), .capture_clock_primary(capture_clock_primary),
        .capture_clock_secondary(capture_clock_secondary), .capture_strobe(capture_strobe),
        .fabric_clock(fabric_clock)
    );
    always #5 clk = ~clk;
    task chk(input logic [35:0] g, input logic [35:0] e);
        checks++;
        fails += g !== e;
        if (g !== e) $display("Error at %0t: got %h expected %h", $time, g, e);
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (s_axi_bvalid !== 1'h1)
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (s_axi_rvalid !== 1'h1)
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask
    task slip_pulse;
        slip_req <= 1'h1;
        src.fab_pulse;
        slip_req <= 1'h0;
    endtask
    task t_regs;
        rd(4'h0);
        chk({d, r}, {32'h1, 2'h0});
        wr(4'h0, 32'hffff_fc84);
        chk(r, 2'h0);
        rd(4'h0);
        chk(d, 32'h84);
        rd(4'h8);
        chk({d, r}, {32'h0, 2'h2});
        wr(4'h8, 32'h0);
        chk(r, 2'h2);
        $display("regs done");
    endtask
    task t_ratio;
        for (int n = 1; n <= 4; n++)
        begin
            wr(4'h0, n);
            src.send(8'hc5, 2 * n, n);
            chk(word, 8'hc5 & ((1 << n) - 1));
        end
        $display("ratio done");
    endtask
    task t_slip;
        wr(4'h0, 32'h4);
        slip_pulse;
        src.send(8'h6c, 8, 4);
        chk(word, 4'hc);
        wr(4'h0, 32'h84);
        slip_pulse;
        src.send(8'h6c, 8, 4);
        chk(word, 4'h6);
        $display("slip done");
    endtask
    task t_hold;
        wr(4'h0, 32'h4);
        src.send(8'h0f, 8, 4);
        final_reg_enable <= 1'h0;
        src.send(8'h03, 8, 4);
        chk(word, 4'hf);
        final_reg_enable <= 1'h1;
        src.fab_pulse;
        chk(word, 4'h3);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk);
        chk(word, 4'h0);
        reset_n <= 1'h1;
        rd(4'h0);
        chk(d, 32'h1);
        $display("hold done");
    endtask
    task t_master;
        wr(4'h0, 32'h14);
        src.send(8'h0d, 8, 4);
        chk(phase_valid, 1'h1);
        chk(phase_early_late, 1'h1);
        chk(cascade_out, 1'h1);
        src.send(8'h00, 8, 4);
        chk(phase_valid, 1'h0);
        chk(unregistered_sample_out, 1'h1);
        casc_lvl <= 1'h0;
        src.send(8'h0d, 8, 4);
        chk(phase_valid, 1'h1);
        chk(phase_early_late, 1'h0);
        $display("master done");
    endtask
    task t_casc;
        wr(4'h0, 32'h16);
        src.send(8'h35, 6, 6);
        chk(word, 4'h5);
        mirror <= 1'h1;
        wr(4'h0, 32'h26);
        src.send(8'h35, 6, 6);
        chk(word, 4'h2);
        chk(cascade_out, 1'h0);
        chk(phase_valid, 1'h0);
        mirror <= 1'h0;
        $display("cascade done");
    endtask
    task end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        t_regs;
        t_ratio;
        t_slip;
        t_hold;
        t_master;
        t_casc;
        end_sim;
    end
    // Tests need about 1700 cycles
    initial
    begin
        repeat (10000) @(posedge clk);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end
endmodule // ids_input_deserializer_test
bind ids_input_deserializer ids_chk u_chk (
    .clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .serial_in(serial_in),
    .final_reg_enable(final_reg_enable), .fabric_clock(fabric_clock),
    .unregistered_sample_out(unregistered_sample_out), .phase_early_late(phase_early_late),
    .phase_valid(phase_valid), .parallel_word_out_0(parallel_word_out_0),
    .parallel_word_out_1(parallel_word_out_1), .parallel_word_out_2(parallel_word_out_2),
    .parallel_word_out_3(parallel_word_out_3)
);
